// ### lpddr2_command_decode.sv
// Operation
// [R1] Any undefined operation is illegal until reset and reinitialization.
// [R2] Idle means every bank precharged with no row open.
// [R3] Command identified only from chip select, CA0-CA3 and clock enable.
// [R4] Bank commands act on the bank given by their bank address.
// [R5] Auto-precharge high closes the bank after the burst; low keeps row.
// [R6] Controller drives every don't-care position to a valid level.
// [R7] Self refresh and deep power-down exit on clock enable alone.
// [R8] Each command spans a rising and a falling transfer, both captured.
// [R9] Chip select and clock enable are sampled only at rising edges.
// [R10] Per-bank refresh accepted only when the device has eight banks.
// [R11] Lowest column bit is not sent and is supplied as zero.
// [R12] First-edge command encodings follow the fixed CA0-CA3 table.
// [R13] Clock enable rising with chip select high leaves power-down.
// [R14] Controller sends only no-operation until power-down exit time passes.
// [R15] Resetting power-down exit goes idle only when init wait expired.
// [R16] Controller gives two clock toggles before exit period counts.
// [R17] No-operation is chip select high, or low with CA0-CA2 high.
`timescale 1ns/1ps
`default_nettype none
module lpddr2_command_decode #(
  parameter int NUM_BANKS = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [9:0] ca_rise_in,
  input wire logic [9:0] ca_fall_in,
  input wire logic init_done_in,
  output logic cmd_valid_out,
  output lpddr2_cmd_pkg::cmd_t cmd_out,
  output logic [2:0] bank_out,
  output logic [14:0] row_out,
  output logic [11:0] col_out,
  output logic auto_pre_out,
  output logic all_banks_out,
  output logic [7:0] mr_addr_out,
  output logic [7:0] mr_data_out,
  output logic [7:0] bank_open_out,
  output lpddr2_cmd_pkg::dev_state_t state_out,
  output logic illegal_out
);

  if (NUM_BANKS != 4 && NUM_BANKS != 8) begin : g_bad_banks
    $error("NUM_BANKS must be 4 or 8");
  end

  typedef struct packed {
    lpddr2_cmd_pkg::dev_state_t st;
    logic cke_prev;
    logic [7:0] open;
    logic valid;
    lpddr2_cmd_pkg::cmd_t cmd;
    logic [2:0] bank;
    logic [14:0] row;
    logic [11:0] col;
    logic ap;
    logic ab;
    logic [7:0] ma;
    logic [7:0] op;
    logic illegal;
  } regs_t;

  regs_t r;
  regs_t next_r;
  lpddr2_cmd_pkg::cmd_t cmd;
  logic [2:0] ba;
  logic bank_ok;
  logic bank_is_open;
  logic [7:0] ma;

  ////////////////////////////////////////////////////////////////////////
  // [R3] [R9] [R12] [R17] rising-edge class
  lpddr2_cmd_classify classify (
    .cke_prev_in(r.cke_prev),
    .cke_in(cke_in),
    .cs_n_in(cs_n_in),
    .ca_in(ca_rise_in[3:0]),
    .cmd_out(cmd)
  );

  // [R4] bank address from the command
  assign ba = ca_rise_in[lpddr2_cmd_pkg::RISE_BA_LSB +: 3];
  assign bank_ok = 32'(ba) < NUM_BANKS;
  assign bank_is_open = r.open[ba];
  // [R8] address spans both transfers
  assign ma = {ca_fall_in[lpddr2_cmd_pkg::FALL_MA_HI_LSB +: 2],
               ca_rise_in[lpddr2_cmd_pkg::RISE_MA_LSB +: 6]};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.cke_prev = cke_in;
    next_r.valid = 1'b0;
    next_r.cmd = cmd;
    next_r.bank = ba;
    // [R8] [R4] capture both halves
    next_r.row = {ca_fall_in[lpddr2_cmd_pkg::FALL_ROW_TOP_LSB +: 2],
                  ca_rise_in[lpddr2_cmd_pkg::RISE_ROW_HI_LSB +: 5],
                  ca_fall_in[7:0]};
    // [R11] column bit zero forced low
    next_r.col = {ca_fall_in[lpddr2_cmd_pkg::FALL_COL_LSB +: 9],
                  ca_rise_in[lpddr2_cmd_pkg::RISE_COL_LSB +: 2], 1'b0};
    next_r.ap = ca_fall_in[lpddr2_cmd_pkg::FALL_AP_POS];
    next_r.ab = ca_rise_in[lpddr2_cmd_pkg::RISE_AB_POS];
    next_r.ma = ma;
    next_r.op = ca_fall_in[lpddr2_cmd_pkg::FALL_OP_LSB +: 8];
    unique case (r.st)
      lpddr2_cmd_pkg::st_power_on: begin
        // Clock enable may still rise or stay low while power settles
        if (cmd == lpddr2_cmd_pkg::cmd_mr_write &&
            ma == lpddr2_cmd_pkg::MA_RESET) begin
          next_r.valid = 1'b1;
          next_r.st = lpddr2_cmd_pkg::st_resetting;
        end else if (!(cmd inside {lpddr2_cmd_pkg::cmd_nop,
                                   lpddr2_cmd_pkg::cmd_pd_exit,
                                   lpddr2_cmd_pkg::cmd_pd_hold})) begin
          next_r.st = lpddr2_cmd_pkg::st_illegal;
        end
      end
      lpddr2_cmd_pkg::st_resetting: begin
        unique case (cmd)
          lpddr2_cmd_pkg::cmd_nop: begin
            if (init_done_in) begin
              next_r.st = lpddr2_cmd_pkg::st_ready;
            end
          end
          lpddr2_cmd_pkg::cmd_mr_read,
          lpddr2_cmd_pkg::cmd_mr_write: next_r.valid = 1'b1;
          lpddr2_cmd_pkg::cmd_pd_enter:
            next_r.st = lpddr2_cmd_pkg::st_reset_pd;
          default: next_r.st = lpddr2_cmd_pkg::st_illegal;
        endcase
      end
      lpddr2_cmd_pkg::st_ready: begin
        next_r.valid = cmd != lpddr2_cmd_pkg::cmd_nop;
        unique case (cmd)
          lpddr2_cmd_pkg::cmd_nop,
          lpddr2_cmd_pkg::cmd_burst_stop,
          lpddr2_cmd_pkg::cmd_mr_read,
          lpddr2_cmd_pkg::cmd_mr_write: begin
          end
          lpddr2_cmd_pkg::cmd_activate: begin
            if (!bank_ok || bank_is_open) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end else begin
              next_r.open[ba] = 1'b1;
            end
          end
          lpddr2_cmd_pkg::cmd_read,
          lpddr2_cmd_pkg::cmd_write: begin
            if (!bank_ok || !bank_is_open) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end else if (next_r.ap) begin
              // [R5] auto precharge closes the row
              next_r.open[ba] = 1'b0;
            end
          end
          lpddr2_cmd_pkg::cmd_precharge: begin
            if (next_r.ab) begin
              next_r.open = '0;
            end else if (!bank_ok) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end else begin
              next_r.open[ba] = 1'b0;
            end
          end
          lpddr2_cmd_pkg::cmd_refresh_all: begin
            // [R2] refresh needs all banks precharged
            if (r.open != '0) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end
          end
          lpddr2_cmd_pkg::cmd_refresh_bank: begin
            // [R10] eight-bank parts only
            if (NUM_BANKS != lpddr2_cmd_pkg::BANKS_FOR_PER_BANK_REFRESH ||
                bank_is_open) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end
          end
          lpddr2_cmd_pkg::cmd_pd_enter: begin
            next_r.st = (r.open == '0) ? lpddr2_cmd_pkg::st_idle_pd
                                       : lpddr2_cmd_pkg::st_active_pd;
          end
          lpddr2_cmd_pkg::cmd_self_refresh,
          lpddr2_cmd_pkg::cmd_deep_pd: begin
            // [R2] idle state means no open row
            if (r.open != '0) begin
              next_r.st = lpddr2_cmd_pkg::st_illegal;
            end else if (cmd == lpddr2_cmd_pkg::cmd_deep_pd) begin
              next_r.st = lpddr2_cmd_pkg::st_deep_pd;
            end else begin
              next_r.st = lpddr2_cmd_pkg::st_self_refresh;
            end
          end
          default: next_r.st = lpddr2_cmd_pkg::st_illegal;
        endcase
        if (next_r.st == lpddr2_cmd_pkg::st_illegal) begin
          next_r.valid = 1'b0;
        end
      end
      lpddr2_cmd_pkg::st_idle_pd,
      lpddr2_cmd_pkg::st_active_pd,
      lpddr2_cmd_pkg::st_reset_pd: begin
        // [R13] exit needs chip select high
        if (cmd == lpddr2_cmd_pkg::cmd_pd_exit && cs_n_in) begin
          if (r.st != lpddr2_cmd_pkg::st_reset_pd) begin
            next_r.st = lpddr2_cmd_pkg::st_ready;
          // [R15] init wait decides the target
          end else if (init_done_in) begin
            next_r.st = lpddr2_cmd_pkg::st_ready;
          end else begin
            next_r.st = lpddr2_cmd_pkg::st_resetting;
          end
        end else if (cmd != lpddr2_cmd_pkg::cmd_pd_hold) begin
          next_r.st = lpddr2_cmd_pkg::st_illegal;
        end
      end
      lpddr2_cmd_pkg::st_self_refresh,
      lpddr2_cmd_pkg::st_deep_pd: begin
        // [R7] exit on clock enable alone, chip select ignored
        if (cke_in) begin
          next_r.st = (r.st == lpddr2_cmd_pkg::st_deep_pd)
                      ? lpddr2_cmd_pkg::st_power_on
                      : lpddr2_cmd_pkg::st_ready;
          next_r.open = '0;
        end
      end
      // [R1] held until reset and full reinitialization
      lpddr2_cmd_pkg::st_illegal: next_r.open = '0;
      default: next_r.st = lpddr2_cmd_pkg::st_illegal;
    endcase
    // Registered so the flag leaves the block straight from a flop
    next_r.illegal = next_r.st == lpddr2_cmd_pkg::st_illegal;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '{st: lpddr2_cmd_pkg::st_power_on, cmd: lpddr2_cmd_pkg::cmd_nop,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign cmd_valid_out = r.valid;
  assign cmd_out = r.cmd;
  assign bank_out = r.bank;
  assign row_out = r.row;
  assign col_out = r.col;
  assign auto_pre_out = r.ap;
  assign all_banks_out = r.ab;
  assign mr_addr_out = r.ma;
  assign mr_data_out = r.op;
  assign bank_open_out = r.open;
  assign state_out = r.st;
  assign illegal_out = r.illegal;

endmodule
`default_nettype wire

// ### lpddr2_cmd_pkg.sv
package lpddr2_cmd_pkg;

  // Command classes seen at a rising clock edge
  typedef enum logic [3:0] {
    cmd_nop, cmd_mr_write, cmd_mr_read, cmd_refresh_bank, cmd_refresh_all,
    cmd_activate, cmd_write, cmd_read, cmd_precharge, cmd_burst_stop,
    cmd_self_refresh, cmd_deep_pd, cmd_pd_enter, cmd_pd_exit,
    cmd_pd_hold, cmd_undefined
  } cmd_t;

  // Bus interface states
  typedef enum logic [3:0] {
    st_power_on, st_resetting, st_ready, st_idle_pd, st_active_pd,
    st_reset_pd, st_self_refresh, st_deep_pd, st_illegal
  } dev_state_t;

  localparam int CA_WIDTH = 10;
  localparam int BANK_BITS = 3;
  localparam int ROW_BITS = 15;
  localparam int COL_BITS = 12;
  localparam int MA_BITS = 8;
  localparam int OP_BITS = 8;

  // Field positions on the rising-edge transfer
  localparam int RISE_BA_LSB = 7;
  localparam int RISE_ROW_HI_LSB = 2;
  localparam int RISE_COL_LSB = 5;
  localparam int RISE_AB_POS = 4;
  localparam int RISE_MA_LSB = 4;
  // Field positions on the falling-edge transfer
  localparam int FALL_AP_POS = 0;
  localparam int FALL_COL_LSB = 1;
  localparam int FALL_ROW_TOP_LSB = 8;
  localparam int FALL_MA_HI_LSB = 0;
  localparam int FALL_OP_LSB = 2;

  // Mode register address that starts device auto initialization
  localparam logic [7:0] MA_RESET = 8'h3f;
  localparam int BANKS_FOR_PER_BANK_REFRESH = 8;

endpackage

// ### lpddr2_cmd_classify.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr2_cmd_classify (
  input wire logic cke_prev_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [3:0] ca_in,
  output lpddr2_cmd_pkg::cmd_t cmd_out
);

  always_comb begin
    cmd_out = lpddr2_cmd_pkg::cmd_undefined;
    unique case ({cke_prev_in, cke_in})
      2'b11: begin
        if (cs_n_in || ca_in[2:0] == 3'h7) begin
          cmd_out = lpddr2_cmd_pkg::cmd_nop;
        end else if (ca_in[1:0] == 2'h0) begin
          unique case (ca_in[3:2])
            2'h0: cmd_out = lpddr2_cmd_pkg::cmd_mr_write;
            2'h2: cmd_out = lpddr2_cmd_pkg::cmd_mr_read;
            2'h1: cmd_out = lpddr2_cmd_pkg::cmd_refresh_bank;
            2'h3: cmd_out = lpddr2_cmd_pkg::cmd_refresh_all;
          endcase
        end else if (ca_in[1:0] == 2'h2) begin
          cmd_out = lpddr2_cmd_pkg::cmd_activate;
        end else if (ca_in[1:0] == 2'h1) begin
          cmd_out = ca_in[2] ? lpddr2_cmd_pkg::cmd_read
                             : lpddr2_cmd_pkg::cmd_write;
        end else begin
          cmd_out = ca_in[3] ? lpddr2_cmd_pkg::cmd_precharge
                             : lpddr2_cmd_pkg::cmd_burst_stop;
        end
      end
      2'b10: begin
        if (cs_n_in) begin
          cmd_out = lpddr2_cmd_pkg::cmd_pd_enter;
        end else if (ca_in[2:0] == 3'h4) begin
          cmd_out = lpddr2_cmd_pkg::cmd_self_refresh;
        end else if (ca_in[2:0] == 3'h3) begin
          cmd_out = lpddr2_cmd_pkg::cmd_deep_pd;
        end else begin
          cmd_out = lpddr2_cmd_pkg::cmd_undefined;
        end
      end
      2'b01: cmd_out = lpddr2_cmd_pkg::cmd_pd_exit;
      2'b00: cmd_out = lpddr2_cmd_pkg::cmd_pd_hold;
    endcase
  end

endmodule
`default_nettype wire

// ### lpddr2_command_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr2_command_decode_checker #(
  parameter int NUM_BANKS = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [9:0] ca_rise_in,
  input wire logic [9:0] ca_fall_in,
  input wire logic cmd_valid_out,
  input wire lpddr2_cmd_pkg::cmd_t cmd_out,
  input wire logic [2:0] bank_out,
  input wire logic [11:0] col_out,
  input wire logic auto_pre_out,
  input wire logic [7:0] bank_open_out,
  input wire lpddr2_cmd_pkg::dev_state_t state_out,
  input wire logic illegal_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  property p_nop;
    !$past(reset_in) && cke_in && $past(cke_in) && cs_n_in |=> !cmd_valid_out;
  endproperty
  a_nop: assert property (p_nop) else $error("deselect gave command");
  property p_act;
    !$past(reset_in) && cke_in && $past(cke_in) && !cs_n_in &&
      ca_rise_in[1:0] == 2'b10 |=> cmd_out == lpddr2_cmd_pkg::cmd_activate;
  endproperty
  a_act: assert property (p_act) else $error("activate misdecoded");
  property p_bank;
    cmd_valid_out && cmd_out == lpddr2_cmd_pkg::cmd_activate
      |-> bank_out == $past(ca_rise_in[9:7]);
  endproperty
  a_bank: assert property (p_bank) else $error("wrong bank");
  property p_col;
    cmd_valid_out && cmd_out inside {lpddr2_cmd_pkg::cmd_read,
      lpddr2_cmd_pkg::cmd_write}
      |-> col_out == {$past(ca_fall_in[9:1]), $past(ca_rise_in[6:5]), 1'b0};
  endproperty
  a_col: assert property (p_col) else $error("wrong column");
  property p_ap;
    cmd_valid_out && cmd_out inside {lpddr2_cmd_pkg::cmd_read,
      lpddr2_cmd_pkg::cmd_write} |-> bank_open_out[bank_out] == !auto_pre_out;
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge wrong");
  property p_sticky;
    illegal_out |=> illegal_out && !cmd_valid_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("left illegal");
  property p_pd_exit;
    state_out == lpddr2_cmd_pkg::st_idle_pd && cke_in && cs_n_in
      |=> state_out == lpddr2_cmd_pkg::st_ready;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("no pd exit");
  property p_sr_exit;
    state_out == lpddr2_cmd_pkg::st_self_refresh && cke_in
      |=> state_out == lpddr2_cmd_pkg::st_ready;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("no sref exit");
  property p_idle;
    state_out == lpddr2_cmd_pkg::st_idle_pd |-> bank_open_out == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("row open in idle");
  property p_refpb;
    cmd_valid_out && cmd_out == lpddr2_cmd_pkg::cmd_refresh_bank
      |-> NUM_BANKS == 8;
  endproperty
  a_refpb: assert property (p_refpb) else $error("bank refresh");
endmodule
bind lpddr2_command_decode lpddr2_command_decode_checker #(
  .NUM_BANKS(NUM_BANKS)
) i_chk (.clk_in, .reset_in, .cke_in, .cs_n_in, .ca_rise_in, .ca_fall_in,
  .cmd_valid_out, .cmd_out, .bank_out, .col_out, .auto_pre_out,
  .bank_open_out, .state_out, .illegal_out);
`default_nettype wire

// ### lpddr2_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr2_ctrl_model (
  input wire logic clk_in,
  output logic cke_out,
  output logic cs_n_out,
  output logic [9:0] ca_rise_out,
  output logic [9:0] ca_fall_out
);
  initial begin
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    ca_rise_out = 10'h000;
    ca_fall_out = 10'h000;
  end
  task automatic issue(input logic k, input logic c,
    input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_in);
    #1;
    cke_out = k;
    cs_n_out = c;
    ca_rise_out = r;
    ca_fall_out = f;
    @(posedge clk_in);
    #1;
    // Deselected bus shows the inverse, so no stale command can match
    cs_n_out = 1'b1;
    ca_rise_out = ~r;
    ca_fall_out = ~f;
  endtask
endmodule
`default_nettype wire

// ### lpddr2_command_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lpddr2_command_decode_tb;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic init_done = 1'b0;
  logic cke, cs_n, valid, ap, bad, ab_all;
  logic [7:0] ma, op;
  logic [9:0] car, caf;
  logic [2:0] bank;
  logic [14:0] row;
  logic [11:0] col;
  logic [7:0] open_banks;
  lpddr2_cmd_pkg::cmd_t cmd;
  lpddr2_cmd_pkg::dev_state_t st;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [3:0] codes [6] = '{4'h8, 4'hc, 4'h4, 4'hb, 4'h3, 4'h7};
  lpddr2_cmd_pkg::cmd_t exp_cmd [6] = '{lpddr2_cmd_pkg::cmd_mr_read,
    lpddr2_cmd_pkg::cmd_refresh_all, lpddr2_cmd_pkg::cmd_refresh_bank,
    lpddr2_cmd_pkg::cmd_precharge, lpddr2_cmd_pkg::cmd_burst_stop,
    lpddr2_cmd_pkg::cmd_nop};

  always #20 clk_in = ~clk_in;

  lpddr2_ctrl_model i_lpddr2_ctrl_model (.clk_in(clk_in), .cke_out(cke),
    .cs_n_out(cs_n), .ca_rise_out(car), .ca_fall_out(caf));
  lpddr2_command_decode #(.NUM_BANKS(8)) i_lpddr2_command_decode (
    .clk_in(clk_in), .reset_in(reset_in), .cke_in(cke), .cs_n_in(cs_n),
    .ca_rise_in(car), .ca_fall_in(caf), .init_done_in(init_done),
    .cmd_valid_out(valid), .cmd_out(cmd), .bank_out(bank), .row_out(row),
    .col_out(col), .auto_pre_out(ap), .all_banks_out(ab_all),
    .mr_addr_out(ma), .mr_data_out(op), .bank_open_out(open_banks),
    .state_out(st),
    .illegal_out(bad));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic go(input logic k, input logic c, input logic [9:0] r,
    input logic [9:0] f);
    i_lpddr2_ctrl_model.issue(k, c, r, f);
  endtask

  task automatic t_init();
    init_done = 1'b0;
    go(1'b1, 1'b0, 10'h3f0, 10'h158);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_resetting));
    check(32'({ma, op}), 32'({lpddr2_cmd_pkg::MA_RESET, 8'h56}));
    go(1'b0, 1'b1, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_reset_pd));
    go(1'b1, 1'b1, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_resetting));
    init_done = 1'b1;
    go(1'b1, 1'b0, 10'h3ff, 10'h000);
    check(32'({st, valid}), 32'({lpddr2_cmd_pkg::st_ready, 1'b0}));
  endtask

  task automatic t_rw();
    go(1'b1, 1'b0, 10'h2d6, 10'h2a5);
    check(32'({valid, cmd, bank}), 32'({1'b1, lpddr2_cmd_pkg::cmd_activate,
      3'd5}));
    check(32'(row), 32'h55a5);
    go(1'b1, 1'b0, 10'h2e1, 10'h2aa);
    check(32'({cmd, col, open_banks}), 32'({lpddr2_cmd_pkg::cmd_write,
      12'haae, 8'h20}));
    go(1'b1, 1'b0, 10'h285, 10'h001);
    check(32'({cmd, ap, open_banks}), 32'({lpddr2_cmd_pkg::cmd_read, 1'b1,
      8'h00}));
    go(1'b1, 1'b0, 10'h102, 10'h000);
    check(32'(open_banks), 32'h04);
    go(1'b1, 1'b0, 10'h01b, 10'h000);
    check(32'({cmd, ab_all, open_banks}), 32'({lpddr2_cmd_pkg::cmd_precharge,
      1'b1, 8'h00}));
  endtask

  task automatic t_table();
    for (int i = 0; i < 6; i++) begin
      go(1'b1, 1'b0, {6'h00, codes[i]}, 10'h000);
      check(32'({valid, cmd}), 32'({i < 5, exp_cmd[i]}));
    end
  endtask

  task automatic t_power();
    go(1'b0, 1'b1, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_idle_pd));
    go(1'b0, 1'b0, 10'h2d6, 10'h000);
    check(32'({st, valid}), 32'({lpddr2_cmd_pkg::st_idle_pd, 1'b0}));
    go(1'b1, 1'b1, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_ready));
    go(1'b1, 1'b1, 10'h000, 10'h000);
    check(32'({st, valid}), 32'({lpddr2_cmd_pkg::st_ready, 1'b0}));
    go(1'b0, 1'b0, 10'h004, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_self_refresh));
    go(1'b1, 1'b0, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_ready));
    go(1'b1, 1'b1, 10'h000, 10'h000);
    go(1'b0, 1'b0, 10'h003, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_deep_pd));
    go(1'b1, 1'b1, 10'h000, 10'h000);
    check(32'(st), 32'(lpddr2_cmd_pkg::st_power_on));
  endtask

  task automatic t_illegal();
    go(1'b1, 1'b0, 10'h082, 10'h000);
    go(1'b1, 1'b0, 10'h082, 10'h000);
    check(32'({bad, valid}), 32'h2);
    go(1'b1, 1'b1, 10'h000, 10'h000);
    check(32'(bad), 32'h1);
  endtask

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_in = 1'b1;
    init_done = 1'b0;
    repeat (20) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
  endtask

  initial begin
    do_reset();
    t_init();
    t_rw();
    t_table();
    t_power();
    t_init();
    t_illegal();
    do_reset();
    check(32'({bad, st}), 32'(lpddr2_cmd_pkg::st_power_on));
    t_init();
    results();
  end
endmodule
`default_nettype wire
